// [core/ifd_pkg.sv]
/*
  Shared constants and carriers for the instruction format decoder:
  opcode map, field positions, cycle counts and the fetch and dispatch structs.
  Assumes every user imports the whole package; nothing here holds state.
*/
package ifd_pkg;

  localparam int IFD_WORD_W = 24;
  localparam int IFD_OP_LSB = 16;

  // Opcodes with a fixed meaning
  localparam logic [7:0] IFD_OP_NOP      = 8'h00;
  localparam logic [7:0] IFD_OP_CALL_IND = 8'h01;
  localparam logic [7:0] IFD_OP_CALL_LNG = 8'h02;
  localparam logic [7:0] IFD_OP_GOTO_LNG = 8'h04;
  localparam logic [7:0] IFD_OP_GOTO_IND = 8'h05;
  localparam logic [7:0] IFD_OP_RETURN   = 8'h06;
  localparam logic [7:0] IFD_OP_INT_RET  = 8'h07;
  localparam logic [7:0] IFD_OP_BRA_UNC  = 8'h08;
  localparam logic [7:0] IFD_OP_BRA_COMP = 8'h09;
  localparam logic [7:0] IFD_OP_TBL_RD   = 8'h0A;
  localparam logic [7:0] IFD_OP_TBL_WR   = 8'h0B;
  localparam logic [7:0] IFD_OP_MOV_LNG  = 8'h0C;
  // Opcode ranges of the instruction classes
  localparam logic [7:0] IFD_OP_COND_LO  = 8'h30;
  localparam logic [7:0] IFD_OP_COND_HI  = 8'h3F;
  localparam logic [7:0] IFD_OP_DEFAULT_ACCUMULATOR_REG_LO  = 8'h40;
  localparam logic [7:0] IFD_OP_DEFAULT_ACCUMULATOR_REG_HI  = 8'h7F;
  localparam logic [7:0] IFD_OP_FILE_LO  = 8'h80;
  localparam logic [7:0] IFD_OP_FILE_HI  = 8'h9F;
  localparam logic [7:0] IFD_OP_BIT_LO   = 8'hA0;
  localparam logic [7:0] IFD_OP_BIT_HI   = 8'hAF;
  localparam logic [7:0] IFD_OP_LIT_LO   = 8'hB0;
  localparam logic [7:0] IFD_OP_LIT_HI   = 8'hBF;

  // Field positions inside a program word (low bit of each field); IFD_SKIP_POS is a bit of the opcode
  localparam int IFD_BASE_LSB  = 12;
  localparam int IFD_DMODE_LSB = 10;
  localparam int IFD_DST_LSB   = 6;
  localparam int IFD_SMODE_LSB = 4;
  localparam int IFD_SRC_LSB   = 0;
  localparam int IFD_FILE_LSB  = 0;
  localparam int IFD_DSEL_POS  = 13;
  localparam int IFD_BITL_LSB  = 13;
  localparam int IFD_BITB_LSB  = 6;
  localparam int IFD_L5_LSB    = 7;
  localparam int IFD_LDIFF_POS = 6;
  localparam int IFD_L12_LSB   = 4;
  localparam int IFD_TMODE_LSB = 14;
  localparam int IFD_SKIP_POS  = 3;

  // Instruction cycle counts
  localparam logic [1:0] IFD_CYC_ONE   = 2'h1;
  localparam logic [1:0] IFD_CYC_TWO   = 2'h2;
  localparam logic [1:0] IFD_CYC_THREE = 2'h3;

  typedef enum logic [1:0] {IFD_CAT_WB, IFD_CAT_BIT, IFD_CAT_LIT, IFD_CAT_CTRL} ifd_cat_t;

  typedef struct packed {
    logic                  valid;
    logic [IFD_WORD_W-1:0] word;
  } ifd_fetch_t;

  typedef struct packed {
    logic        valid;
    logic        nop;
    logic        ext;
    ifd_cat_t    cat;
    logic [7:0]  opcode;
    logic        byte_op;
    logic [3:0]  base_work_reg;
    logic [3:0]  source_work_reg;
    logic [1:0]  src_mode;
    logic [3:0]  dest_work_reg;
    logic [1:0]  dst_mode;
    logic [12:0] file_addr;
    logic        dest_is_file;
    logic [3:0]  bit_pos;
    logic        bit_indirect;
    logic [15:0] literal;
    logic [22:0] prog_addr;
    logic [1:0]  table_mode;
    logic [1:0]  cycles;
  } ifd_dec_t;

endpackage

// [core/ifd_decoder.sv]
/*
  Instruction format decoder: splits program words into fields, joins two-word
  instructions and paces each instruction over one to three instruction cycles.
  Assumes the fetch unit and datapath run on sys_clk; cond_taken and skip_taken
  arrive in the cycle after the branch or skip was dispatched.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - 24-bit word, top 8 bits are the opcode, the rest operand fields.
// - exactly three opcodes span two program words; all others one.
// - a two-word instruction takes its fields from both 24-bit words.
// - a second word alone has a zero opcode and runs as a no-operation.
// - one cycle normally; a taken test or PC change adds one or two NOP cycles.
// - branches, indirect jumps, table moves and returns take two or three cycles.
// - every instruction falls in word/byte, bit, literal or control class.
// - register word/byte ops give base, source and destination with modes.
// - file ops give a file address and a file-or-work_reg_zero target.
// - bit ops name a register or file; position literal or from base.
// - literal moves give a literal and the register or file to load.
// - literal arithmetic uses base and literal; destination only if different.
// - control ops give a program address and, for tables, the transfer mode.
// - taken skips cost two or three cycles; double-word moves cost two.
module ifd_decoder
  import ifd_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire ifd_fetch_t fetch,
  output logic            fetch_ready,
  input  wire logic       cond_taken,
  input  wire logic       skip_taken,
  output ifd_dec_t        dec
);

  typedef enum logic [1:0] {IFD_S_RUN, IFD_S_EXT, IFD_S_WAIT} ifd_state_t;
  ifd_state_t             state_r, state_nxt;
  logic [1:0]             wait_r, wait_nxt;
  logic [IFD_WORD_W-1:0]  head_r, head_nxt;
  logic                   kill_ext_r, kill_ext_nxt;
  logic                   kill_pend_r, kill_pend_nxt;
  logic                   ready_r, ready_nxt;
  ifd_dec_t               dec_r, dec_nxt;
  logic                   take;
  logic                   kill_now;
  logic [7:0]             op_in;

  function automatic logic two_word(input logic [7:0] op);
    two_word = (op == IFD_OP_CALL_LNG) || (op == IFD_OP_GOTO_LNG) || (op == IFD_OP_MOV_LNG);
  endfunction
  function automatic logic in_range(input logic [7:0] op, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (op >= lo) && (op <= hi);
  endfunction

  // Class of an opcode; unknown codes below 8'h40 fall to control, others to word/byte handling
  function automatic ifd_cat_t cat_of(input logic [7:0] op);
    if (in_range(op, IFD_OP_BIT_LO, IFD_OP_BIT_HI))
      cat_of = IFD_CAT_BIT;
    else if (in_range(op, IFD_OP_LIT_LO, IFD_OP_LIT_HI) || op == IFD_OP_MOV_LNG)
      cat_of = IFD_CAT_LIT;
    else if (op < IFD_OP_DEFAULT_ACCUMULATOR_REG_LO)
      cat_of = IFD_CAT_CTRL;
    else
      cat_of = IFD_CAT_WB;
  endfunction

  // Own cycle count; conditional and skip extras come from the datapath later
  function automatic logic [1:0] cycles_of(input logic [7:0] op);
    case (op)
      IFD_OP_RETURN, IFD_OP_INT_RET:                  cycles_of = IFD_CYC_THREE;
      IFD_OP_CALL_IND, IFD_OP_GOTO_IND, IFD_OP_BRA_UNC,
      IFD_OP_BRA_COMP, IFD_OP_TBL_RD, IFD_OP_TBL_WR:  cycles_of = IFD_CYC_TWO;
      IFD_OP_CALL_LNG, IFD_OP_GOTO_LNG, IFD_OP_MOV_LNG: cycles_of = IFD_CYC_TWO;
      default:                                        cycles_of = IFD_CYC_ONE;
    endcase
  endfunction

  // Field split of one instruction; w2 is only read for two-word opcodes
  function automatic ifd_dec_t decode(input logic [IFD_WORD_W-1:0] w1, input logic [IFD_WORD_W-1:0] w2);
    ifd_dec_t   d;
    logic [7:0] op;
    d = '0;
    op = w1[IFD_OP_LSB +: 8];
    d.valid = 1'b1;
    d.nop = (op == IFD_OP_NOP);
    d.opcode = op;
    d.cat = cat_of(op);
    d.cycles = cycles_of(op);
    d.byte_op = op[0];
    case (d.cat)
      IFD_CAT_WB:
      begin
        if (in_range(op, IFD_OP_FILE_LO, IFD_OP_FILE_HI))
        begin
          d.file_addr = w1[IFD_FILE_LSB +: 13];
          d.dest_is_file = w1[IFD_DSEL_POS];
        end
        else
        begin
          d.base_work_reg = w1[IFD_BASE_LSB +: 4];
          d.dst_mode = w1[IFD_DMODE_LSB +: 2];
          d.dest_work_reg = w1[IFD_DST_LSB +: 4];
          d.src_mode = w1[IFD_SMODE_LSB +: 2];
          d.source_work_reg = w1[IFD_SRC_LSB +: 4];
        end
      end
      IFD_CAT_BIT:
      begin
        d.bit_pos = {op[2], w1[IFD_BITL_LSB +: 3]};
        d.bit_indirect = op[1];
        d.dest_is_file = op[0];
        d.file_addr = w1[IFD_FILE_LSB +: 13];
        d.source_work_reg = w1[IFD_SRC_LSB +: 4];
        d.src_mode = w1[IFD_SMODE_LSB +: 2];
        d.base_work_reg = w1[IFD_BITB_LSB +: 4]; // Supplies the bit index when indirect
      end
      IFD_CAT_LIT:
      begin
        if (op == IFD_OP_MOV_LNG)
        begin
          d.literal = w2[15:0];
          d.dest_work_reg = w1[IFD_SRC_LSB +: 4];
          d.ext = 1'b1;
        end
        else if (op[IFD_SKIP_POS])
        begin
          d.base_work_reg = w1[IFD_BASE_LSB +: 4];
          d.literal = {11'h000, w1[IFD_L5_LSB +: 5]};
          d.dest_work_reg = w1[IFD_LDIFF_POS] ? w1[IFD_SRC_LSB +: 4] : w1[IFD_BASE_LSB +: 4];
          d.dst_mode = w1[IFD_LDIFF_POS] ? w1[IFD_SMODE_LSB +: 2] : 2'h0;
        end
        else if (op[0])
        begin
          d.literal = {13'h0000, w1[IFD_BITL_LSB +: 3]};
          d.file_addr = w1[IFD_FILE_LSB +: 13];
          d.dest_is_file = 1'b1;
        end
        else
        begin
          d.literal = {4'h0, w1[IFD_L12_LSB +: 12]};
          d.dest_work_reg = w1[IFD_SRC_LSB +: 4];
        end
      end
      default:
      begin
        d.source_work_reg = w1[IFD_SRC_LSB +: 4]; // Target register for indirect forms
        d.table_mode = w1[IFD_TMODE_LSB +: 2];
        if (two_word(op))
        begin
          d.prog_addr = {w2[6:0], w1[15:0]};
          d.ext = 1'b1;
        end
        else
          d.prog_addr = {7'h00, w1[15:0]};
      end
    endcase
    decode = d;
  endfunction

  // A dispatch slot that does nothing, used for extra cycles and killed words
  function automatic ifd_dec_t nop_slot();
    ifd_dec_t d;
    d = '0;
    d.valid = 1'b1;
    d.nop = 1'b1;
    d.cat = IFD_CAT_CTRL;
    d.cycles = IFD_CYC_ONE;
    nop_slot = d;
  endfunction

  assign take = fetch.valid && ready_r;
  assign op_in = fetch.word[IFD_OP_LSB +: 8];
  // A taken condition or skip voids the next word fetched, even if it is late
  assign kill_now = kill_pend_r || cond_taken || skip_taken;

  // Sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    wait_nxt = wait_r;
    head_nxt = head_r;
    kill_ext_nxt = kill_ext_r;
    kill_pend_nxt = kill_pend_r || cond_taken || skip_taken;
    dec_nxt = '0;
    case (state_r)
      IFD_S_RUN:
      begin
        if (take)
        begin
          kill_pend_nxt = 1'b0;
          if (two_word(op_in))
          begin
            head_nxt = fetch.word;
            kill_ext_nxt = kill_now;
            state_nxt = IFD_S_EXT;
            if (kill_now)
              dec_nxt = nop_slot();
          end
          else if (kill_now)
            dec_nxt = nop_slot();
          else
          begin
            dec_nxt = decode(fetch.word, '0);
            if (dec_nxt.cycles != IFD_CYC_ONE)
            begin
              wait_nxt = dec_nxt.cycles - IFD_CYC_ONE;
              state_nxt = IFD_S_WAIT;
            end
          end
        end
      end
      IFD_S_EXT:
      begin
        if (take)
        begin
          // The head's own slot was this word's fetch, so no further wait
          dec_nxt = kill_ext_r ? nop_slot() : decode(head_r, fetch.word);
          kill_ext_nxt = 1'b0; // A kill arriving now stays pending for the next word
          state_nxt = IFD_S_RUN;
        end
      end
      IFD_S_WAIT:
      begin
        dec_nxt = nop_slot();
        wait_nxt = wait_r - IFD_CYC_ONE;
        if (wait_r == IFD_CYC_ONE)
          state_nxt = IFD_S_RUN;
      end
      default:
        state_nxt = IFD_S_RUN;
    endcase
    ready_nxt = (state_nxt != IFD_S_WAIT);
  end

  // Sequencer registers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= IFD_S_RUN;
      wait_r <= 2'h0;
      head_r <= '0;
      kill_ext_r <= 1'b0;
      kill_pend_r <= 1'b0;
      ready_r <= 1'b0;
      dec_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      wait_r <= wait_nxt;
      head_r <= head_nxt;
      kill_ext_r <= kill_ext_nxt;
      kill_pend_r <= kill_pend_nxt;
      ready_r <= ready_nxt;
      dec_r <= dec_nxt;
    end
  end

  assign fetch_ready = ready_r;
  assign dec = dec_r;

  // Checks next to the logic they guard
  opcode_field_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_r == IFD_S_RUN && take && !kill_now && !two_word(op_in))
      |=> (dec_r.valid && dec_r.opcode == $past(op_in)))
    else $error("dispatched opcode differs from word top byte");
  head_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_r == IFD_S_RUN && take && !kill_now && two_word(op_in))
      |=> (!dec_r.valid && state_r == IFD_S_EXT && fetch_ready))
    else $error("two-word head was dispatched alone");
  pair_join_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_r == IFD_S_EXT && take && !kill_ext_r)
      |=> (dec_r.ext && dec_r.cycles == IFD_CYC_TWO && dec_r.opcode == $past(head_r[IFD_OP_LSB +: 8])))
    else $error("two-word instruction not joined");
  zero_op_nop_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (dec_r.valid && dec_r.opcode == IFD_OP_NOP) |-> dec_r.nop)
    else $error("zero opcode not executed as nop");
  two_cycle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (dec_r.valid && !dec_r.nop && !dec_r.ext && dec_r.cycles == IFD_CYC_TWO)
      |-> (!fetch_ready ##1 (dec_r.nop && fetch_ready)))
    else $error("two-cycle instruction lacks one nop slot");
  return_three_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (dec_r.valid && !dec_r.nop && dec_r.cycles == IFD_CYC_THREE)
      |-> !fetch_ready ##1 (dec_r.valid && dec_r.nop && !fetch_ready) ##1 (dec_r.valid && dec_r.nop && fetch_ready))
    else $error("three-cycle instruction lacks two nop slots");
  kill_slot_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_r == IFD_S_RUN && take && kill_now) |=> (!dec_r.valid || dec_r.nop))
    else $error("word after taken skip or branch was executed");
  kill_pair_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_r == IFD_S_RUN && take && kill_now && two_word(op_in))
      |=> (state_r == IFD_S_EXT && kill_ext_r))
    else $error("skipped two-word instruction keeps its extension");
  bit_class_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (dec_r.valid && !dec_r.nop && dec_r.opcode >= IFD_OP_BIT_LO && dec_r.opcode <= IFD_OP_BIT_HI)
      |-> dec_r.cat == IFD_CAT_BIT)
    else $error("bit opcode placed in wrong class");

endmodule

// [tb/ifd_fetch_model.sv]
/*
  Far-side model of the instruction format decoder: program fetch unit and
  the datapath's taken-branch and performed-skip pulses.
  Assumes the bench pushes program words through push() and drives the mode pins.
*/
`timescale 1ns/1ps
module ifd_fetch_model
  import ifd_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire logic     resetn,
  output ifd_fetch_t    fetch,
  input  wire logic     fetch_ready,
  input  wire ifd_dec_t dec,
  input  wire logic     slow,
  input  wire logic     cond_en,
  input  wire logic     skip_en,
  output logic          cond_taken,
  output logic          skip_taken
);
  logic [23:0] q[$];
  logic        took;

  task automatic push(input logic [23:0] w);
    q.push_back(w);
  endtask

  // A word is held until taken; idle slots invert the last data each cycle, so every second idle slot shows the stale word
  // Outputs other than the word stay unknown until the first edge, which falls inside reset; the word stays unknown until one is offered
  always @(posedge sys_clk)
  begin
    took = resetn && fetch.valid && fetch_ready;
    #1;
    if (took)
      void'(q.pop_front());
    fetch.valid = resetn && (q.size() > 0) && !(slow && took); // Slow mode leaves a gap
    fetch.word  = fetch.valid ? q[0] : ~fetch.word;
    // Datapath answers in the cycle the branch or skip slot is visible
    cond_taken  = cond_en && dec.valid && !dec.nop && (dec.opcode inside {[IFD_OP_COND_LO:IFD_OP_COND_HI]});
    skip_taken  = skip_en && dec.valid && !dec.nop && (dec.opcode inside {[8'hA8:8'hAF]});
  end
endmodule

// [tb/ifd_decoder_tb_top.sv]
/*
  Self-checking bench of the instruction format decoder: issued slots are
  collected and judged per scenario against hand-worked field values.
  Assumes the fetch model holds words until taken and pulses the kill inputs.
*/
`timescale 1ns/1ps
module ifd_decoder_tb_top;
  import ifd_pkg::*;

  logic       sys_clk;
  logic       resetn;
  logic       slow;
  logic       cond_en;
  logic       skip_en;
  ifd_fetch_t fetch;
  logic       fetch_ready;
  logic       cond_taken;
  logic       skip_taken;
  ifd_dec_t   dec;
  ifd_dec_t   sl[$];
  int         err_total    = 0;
  int         total_checks = 0;

  // Single driver of the clock; the first pass turns the unknown start into a high level
  always #2.5 sys_clk = (sys_clk !== 1'b1);

  ifd_decoder u_dut (.sys_clk(sys_clk), .resetn(resetn), .fetch(fetch), .fetch_ready(fetch_ready),
                     .cond_taken(cond_taken), .skip_taken(skip_taken), .dec(dec));

  ifd_fetch_model u_fm (.sys_clk(sys_clk), .resetn(resetn), .fetch(fetch), .fetch_ready(fetch_ready),
                        .dec(dec), .slow(slow), .cond_en(cond_en), .skip_en(skip_en),
                        .cond_taken(cond_taken), .skip_taken(skip_taken));

  // Every issued slot is recorded, one entry per cycle of execution except the empty head cycle of a two-word op
  always @(posedge sys_clk)
    if (dec.valid === 1'b1)
      sl.push_back(dec);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Appends a marker word and waits, bounded, until it issues
  task automatic go();
    int n;
    n = 0;
    sl.delete();
    u_fm.push(24'h400000);
    while (!(sl.size() > 0 && sl[$].opcode === 8'h40 && sl[$].nop === 1'b0) && n < 200)
    begin
      @(posedge sys_clk);
      n++;
    end
    #1;
    chk(32'(n < 200), 32'h1);
  endtask

  task automatic t_wb();
    u_fm.push(24'h41A5C3);
    u_fm.push(24'h803ABC);
    u_fm.push(24'h811ABC);
    go();
    chk(sl.size(), 4);
    chk(sl[0].opcode, 8'h41);
    chk(sl[0].cat, IFD_CAT_WB);
    chk({sl[0].base_work_reg, sl[0].dst_mode, sl[0].dest_work_reg, sl[0].src_mode, sl[0].source_work_reg}, 16'hA5C3);
    chk({sl[0].byte_op, sl[0].cycles}, {1'b1, IFD_CYC_ONE});
    chk({sl[1].cat, sl[1].dest_is_file, sl[1].file_addr}, {IFD_CAT_WB, 1'b1, 13'h1ABC});
    chk({sl[2].dest_is_file, sl[2].byte_op}, 2'h1);
    $display("word and file ops done, slow=%0d", slow);
  endtask

  task automatic t_bit_lit();
    u_fm.push(24'hA0A000);
    u_fm.push(24'hA64000);
    u_fm.push(24'hB01234);
    u_fm.push(24'hB81F80);
    u_fm.push(24'hB821D7);
    u_fm.push(24'hB1A005);
    go();
    chk(sl.size(), 7);
    chk({sl[0].cat, sl[0].bit_pos, sl[0].bit_indirect}, {IFD_CAT_BIT, 4'h5, 1'b0});
    chk({sl[1].cat, sl[1].bit_indirect}, {IFD_CAT_BIT, 1'b1});
    chk({sl[2].cat, sl[2].literal, sl[2].dest_work_reg}, {IFD_CAT_LIT, 16'h0123, 4'h4});
    chk({sl[3].cat, sl[3].literal, sl[3].base_work_reg, sl[3].dest_work_reg, sl[3].dst_mode},
        {IFD_CAT_LIT, 16'h001F, 4'h1, 4'h1, 2'h0});
    chk({sl[4].literal, sl[4].base_work_reg, sl[4].dest_work_reg, sl[4].dst_mode},
        {16'h0003, 4'h2, 4'h7, 2'h1});
    chk({sl[5].cat, sl[5].literal, sl[5].file_addr, sl[5].dest_is_file},
        {IFD_CAT_LIT, 16'h0005, 13'h0005, 1'b1});
    $display("bit and literal ops done");
  endtask

  // Multi-cycle single-word control ops: dispatch slot then NOP slots
  task automatic t_multi();
    logic [7:0] ops[8] = '{8'h08, 8'h09, 8'h01, 8'h05, 8'h0A, 8'h0B, 8'h06, 8'h07};
    logic [1:0] cy[8]  = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3};
    for (int i = 0; i < 8; i++)
    begin
      u_fm.push({ops[i], 16'hC000});
      go();
      chk(sl.size(), 32'(cy[i]) + 1);
      chk({sl[0].cat, sl[0].opcode, sl[0].cycles}, {IFD_CAT_CTRL, ops[i], cy[i]});
      chk({sl[1].nop, sl[cy[i] - 1].nop}, 2'h3);
      if (ops[i] == 8'h0A || ops[i] == 8'h0B)
        chk(sl[0].table_mode, 2'h3);
    end
    $display("multi-cycle control ops done");
  endtask

  task automatic t_two();
    logic [7:0] hd[3] = '{8'h02, 8'h04, 8'h0C};
    for (int i = 0; i < 3; i++)
    begin
      u_fm.push({hd[i], 16'h5678});
      u_fm.push(24'h0012AB);
      go();
      chk(sl.size(), 2);
      chk({sl[0].ext, sl[0].nop, sl[0].opcode, sl[0].cycles}, {2'h2, hd[i], IFD_CYC_TWO});
      if (hd[i] == 8'h0C)
        chk({sl[0].literal, sl[0].dest_work_reg}, {16'h12AB, 4'h8});
      else
        chk(sl[0].prog_addr, 23'h2B5678);
    end
    u_fm.push(24'h0012AB);
    go();
    chk(sl.size(), 2);
    chk({sl[0].nop, sl[0].ext}, 2'h2);
    $display("two-word ops done");
  endtask

  task automatic t_kill();
    cond_en = 1'b1;
    u_fm.push(24'h300000);
    u_fm.push(24'h410000);
    go();
    cond_en = 1'b0;
    chk(sl.size(), 3);
    chk({sl[0].nop, sl[1].nop}, 2'h1);
    skip_en = 1'b1;
    u_fm.push(24'hA80000);
    u_fm.push(24'h045678);
    u_fm.push(24'h0012AB);
    go();
    skip_en = 1'b0;
    chk(sl.size(), 4);
    chk({sl[0].nop, sl[1].nop, sl[2].nop}, 3'h3);
    $display("taken branch and skip done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Reset for 20 cycles, then the scenarios; the first take waits two edges
  initial
  begin
    resetn  = 1'b0;
    slow    = 1'b0;
    cond_en = 1'b0;
    skip_en = 1'b0;
    repeat (20) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(fetch_ready, 1'b1);
    t_wb();
    slow = 1'b1;
    t_wb();
    slow = 1'b0;
    t_bit_lit();
    t_multi();
    t_two();
    t_kill();
    results();
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    #100000;
    err_total++;
    results();
  end
endmodule
